/* File: hw/srgc_cfg.svh */
// Constants for the serializer reset and general configuration block.
`ifndef SRGC_CFG_SVH
`define SRGC_CFG_SVH
`define SRGC_ADDR_RESET     8'h01
`define SRGC_ADDR_GENCFG    8'h03
`define SRGC_RST_KEEP_BIT   0
`define SRGC_RST_FULL_BIT   1
`define SRGC_CRC_BIT        7
`define SRGC_AACK_BIT       5
`define SRGC_FILT_BIT       4
`define SRGC_PASS_BIT       3
`define SRGC_GENCFG_RST     8'hd2
`define SRGC_GENCFG_RSVD    8'h42
`define SRGC_FILT_CYC       2'd2
`define SRGC_SYNC_W         3
`define SRGC_SYNC_STAGES    2
`endif

/* File: hw/srgc_pkg.sv */
// Types shared by the serializer reset and general configuration block.
package srgc_pkg;
    typedef struct packed {
        logic line_sync;
        logic frame_sync;
        logic active_video_flag;
    } srgc_sync_t;

    typedef struct packed {
        logic       crc_chk_en;
        logic       filt_en;
        logic [1:0] auto_ack;
        logic [1:0] pass_thru;
    } srgc_gencfg_t;
endpackage : srgc_pkg

/* File: hw/srgc_top.sv */
// Reset control, general configuration register and sync filter of the serializer.
`timescale 1ns/1ps
`include "srgc_cfg.svh"
module srgc_top (
    input  wire logic               clk_i,
    input  wire logic               sys_rst_i,
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic [7:0]         reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic [7:0]              reg_rdata_o,
    input  wire logic               second_port_select_i,
    input  wire logic [7:0]         strap_i,
    output logic [7:0]              strap_val_o,
    output logic                    strap_reload_o,
    output logic                    restore_regs_o,
    output logic                    logic_rst_o,
    output logic                    crc_chk_en_o,
    input  wire logic               rem_wr_start_i,
    input  wire logic               rem_port_i,
    input  wire logic               rem_other_slave_i,
    input  wire logic               pass_all_i,
    input  wire logic               rem_resp_i,
    input  wire logic               rem_nack_i,
    output logic                    local_ack_o,
    output logic                    local_nack_o,
    input  wire logic               alias_match_i,
    input  wire logic               alias_port_i,
    output logic                    fwd_remote_o,
    input  wire srgc_pkg::srgc_sync_t sync_i,
    output srgc_pkg::srgc_sync_t    sync_o
);
    srgc_pkg::srgc_gencfg_t cfg_q;
    logic                   keep_req_q;
    logic                   full_req_q;
    logic                   full_rst_q;
    logic                   any_rst;
    logic                   wr_rst;
    logic                   wr_cfg;
    logic [7:0]             strap_s1_q;
    logic [7:0]             strap_s2_q;
    logic                   strap_taken_q;
    logic [7:0]             strap_cap_q;
    logic [`SRGC_SYNC_STAGES-1:0] strap_age_q;
    logic                   auto_pend_q;
    logic [`SRGC_SYNC_W-1:0] sync_s1_q;
    logic [`SRGC_SYNC_W-1:0] sync_s2_q;
    logic [`SRGC_SYNC_W-1:0] filt_q;
    logic [1:0]             filt_cnt_q [`SRGC_SYNC_W];
    logic                   port;
    // A named copy of the default lets single reset bits be selected from it.
    localparam logic [7:0]  gencfg_def = `SRGC_GENCFG_RST;

    assign wr_rst = reg_wr_i && (reg_addr_i == `SRGC_ADDR_RESET);
    assign wr_cfg = reg_wr_i && (reg_addr_i == `SRGC_ADDR_GENCFG);
    assign port   = second_port_select_i;
    // The acknowledge, forward and sync filter flops reset on power-on, full reset and logic reset alike.
    assign any_rst = sys_rst_i || full_rst_q || logic_rst_o;

    // Reset request bits: one request gives one internal pulse, then reads 0.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || full_rst_q)
        begin
            keep_req_q  <= 1'b0;
            full_req_q  <= 1'b0;
            logic_rst_o <= 1'b0;
            full_rst_q  <= 1'b0;
        end
        else
        begin
            keep_req_q  <= wr_rst && reg_wdata_i[`SRGC_RST_KEEP_BIT];
            full_req_q  <= wr_rst && reg_wdata_i[`SRGC_RST_FULL_BIT];
            logic_rst_o <= keep_req_q || full_req_q;
            full_rst_q  <= full_req_q;
        end
    end

    // Configuration register: survives the keep-registers reset, not the full one.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || full_rst_q)
        begin
            cfg_q.crc_chk_en <= gencfg_def[`SRGC_CRC_BIT];
            cfg_q.filt_en    <= gencfg_def[`SRGC_FILT_BIT];
            cfg_q.auto_ack   <= {2{gencfg_def[`SRGC_AACK_BIT]}};
            cfg_q.pass_thru  <= {2{gencfg_def[`SRGC_PASS_BIT]}};
        end
        else if (wr_cfg)
        begin
            cfg_q.crc_chk_en     <= reg_wdata_i[`SRGC_CRC_BIT];
            cfg_q.filt_en        <= reg_wdata_i[`SRGC_FILT_BIT];
            cfg_q.auto_ack[port] <= reg_wdata_i[`SRGC_AACK_BIT];
            cfg_q.pass_thru[port] <= reg_wdata_i[`SRGC_PASS_BIT];
        end
    end

    // Register read data; unmapped offsets read as zero.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `SRGC_ADDR_RESET:
                    reg_rdata_o <= {6'h00, full_req_q, keep_req_q};
                `SRGC_ADDR_GENCFG:
                    reg_rdata_o <= `SRGC_GENCFG_RSVD
                                 | ({7'h00, cfg_q.crc_chk_en} << `SRGC_CRC_BIT)
                                 | ({7'h00, cfg_q.auto_ack[port]} << `SRGC_AACK_BIT)
                                 | ({7'h00, cfg_q.filt_en} << `SRGC_FILT_BIT)
                                 | ({7'h00, cfg_q.pass_thru[port]} << `SRGC_PASS_BIT);
                default:
                    reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Strap pins are synchronised and captured once after power-on reset.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            strap_s1_q    <= 8'h00;
            strap_s2_q    <= 8'h00;
            strap_age_q   <= '0;
            strap_taken_q <= 1'b0;
            strap_cap_q   <= 8'h00;
        end
        else
        begin
            strap_s1_q  <= strap_i;
            strap_s2_q  <= strap_s1_q;
            strap_age_q <= {strap_age_q[`SRGC_SYNC_STAGES-2:0], 1'b1};
            // Capture only once the synchroniser holds a real pin sample.
            if (!strap_taken_q && strap_age_q[`SRGC_SYNC_STAGES-1])
            begin
                strap_taken_q <= 1'b1;
                strap_cap_q   <= strap_s2_q;
            end
        end
    end

    // Reload and restore requests go out to the strap-defaulted and restored registers.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            strap_val_o    <= 8'h00;
            strap_reload_o <= 1'b0;
            restore_regs_o <= 1'b0;
        end
        else
        begin
            strap_val_o    <= strap_cap_q;
            strap_reload_o <= keep_req_q;
            restore_regs_o <= keep_req_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            crc_chk_en_o <= gencfg_def[`SRGC_CRC_BIT];
        else
            crc_chk_en_o <= cfg_q.crc_chk_en;
    end

    // Remote write acknowledge: early local ack and suppression of remote answers.
    always_ff @(posedge clk_i)
    begin
        if (any_rst)
        begin
            auto_pend_q  <= 1'b0;
            local_ack_o  <= 1'b0;
            local_nack_o <= 1'b0;
        end
        else
        begin
            local_ack_o  <= 1'b0;
            local_nack_o <= 1'b0;
            if (rem_wr_start_i && cfg_q.auto_ack[rem_port_i]
                && (!rem_other_slave_i || pass_all_i))
            begin
                auto_pend_q <= 1'b1;
                local_ack_o <= 1'b1;
            end
            else if (rem_resp_i)
            begin
                auto_pend_q <= 1'b0;
                local_ack_o  <= !auto_pend_q && !rem_nack_i;
                local_nack_o <= !auto_pend_q && rem_nack_i;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (any_rst)
            fwd_remote_o <= 1'b0;
        else
            fwd_remote_o <= alias_match_i && cfg_q.pass_thru[alias_port_i];
    end

    // Sync inputs: two-flop synchroniser, then a two-clock glitch filter per line.
    always_ff @(posedge clk_i)
    begin
        if (any_rst)
        begin
            sync_s1_q <= '0;
            sync_s2_q <= '0;
        end
        else
        begin
            sync_s1_q <= sync_i;
            sync_s2_q <= sync_s1_q;
        end
    end

    for (genvar g = 0; g < `SRGC_SYNC_W; g++)
    begin : g_filt
        always_ff @(posedge clk_i)
        begin
            if (any_rst)
            begin
                filt_q[g]     <= 1'b0;
                filt_cnt_q[g] <= 2'd0;
            end
            else if (!cfg_q.filt_en || sync_s2_q[g] == filt_q[g])
            begin
                filt_q[g]     <= sync_s2_q[g];
                filt_cnt_q[g] <= 2'd0;
            end
            else if (filt_cnt_q[g] + 2'd1 >= `SRGC_FILT_CYC)
            begin
                filt_q[g]     <= sync_s2_q[g];
                filt_cnt_q[g] <= 2'd0;
            end
            else
                filt_cnt_q[g] <= filt_cnt_q[g] + 2'd1;
        end
    end

    assign sync_o = srgc_pkg::srgc_sync_t'(filt_q);

    // Checks.
    keep_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (wr_rst && reg_wdata_i[`SRGC_RST_KEEP_BIT] && !full_rst_q && !full_req_q)
        |-> ##2 logic_rst_o)
        else $error("logic reset pulse missing");
    keep_regs_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (logic_rst_o && !full_rst_q && !wr_cfg) |=> $stable(cfg_q))
        else $error("logic reset disturbed configuration");
    strap_reload_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        strap_reload_o |-> (strap_val_o == $past(strap_cap_q)) && logic_rst_o)
        else $error("strap reload wrong");
    restore_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        restore_regs_o |-> logic_rst_o ##1 !restore_regs_o)
        else $error("restore pulse wrong");
    full_defaults_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        full_rst_q |=> cfg_q.crc_chk_en && cfg_q.filt_en && cfg_q.auto_ack == 2'b00
                       && cfg_q.pass_thru == 2'b00)
        else $error("full reset left configuration");
    crc_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (wr_cfg && !full_rst_q) |=> ##1 crc_chk_en_o == $past(reg_wdata_i[`SRGC_CRC_BIT], 2))
        else $error("CRC enable not applied");
    auto_nack_a: assert property (@(posedge clk_i) disable iff (any_rst)
        (auto_pend_q && rem_resp_i && !rem_wr_start_i) |=> !local_nack_o)
        else $error("remote nack leaked");
    filt_glitch_a: assert property (@(posedge clk_i) disable iff (any_rst)
        (cfg_q.filt_en && $past(cfg_q.filt_en) && !$past(any_rst) && $changed(filt_q[0]))
        |-> $past(sync_s2_q[0], 1) == $past(sync_s2_q[0], 2))
        else $error("short pulse passed filter");
    pass_fwd_a: assert property (@(posedge clk_i) disable iff (any_rst)
        fwd_remote_o |-> $past(alias_match_i) && $past(cfg_q.pass_thru[alias_port_i]))
        else $error("forward without pass-through");
    req_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        keep_req_q |=> !keep_req_q || $past(wr_rst))
        else $error("reset bit not self-clearing");
endmodule : srgc_top

/* File: verif/srgc_host_model.sv */
// Local register host model driving the byte-strobe register port.
`timescale 1ns/1ps
module srgc_host_model (
    input  wire logic       clk_i,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    initial
    begin
        addr_o  = 8'h00;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end
    // Write data and read address are scrambled once released so stale values cannot pass.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
    endtask : rd
endmodule : srgc_host_model

/* File: verif/tb_serializer_reset_and_general_config.sv */
// Self-checking testbench of the reset and general configuration block.
`timescale 1ns/1ps
module tb_serializer_reset_and_general_config;
    logic                 clk_i     = 1'b0;
    logic                 sys_rst_i = 1'b1;
    logic [7:0]           addr, wdata, rdata, strap_val, d;
    logic [7:0]           strap     = 8'h00;
    logic                 wr, rd, reload, restore, lrst, crc_en, lack, lnack, fwd;
    logic                 sel = 0, rws = 0, rport = 0, roth = 0, pall = 0;
    logic                 rresp = 0, rnack = 0, amatch = 0, aport = 0;
    logic                 p, o, a, n, auto, crc, filt;
    logic                 aack[2], pass[2];
    srgc_pkg::srgc_sync_t sync_i = '0;
    srgc_pkg::srgc_sync_t sync_o;
    logic [2:0]           sync_seen = 3'h0;
    logic                 rd_d      = 1'b0;
    logic [15:0]          exp_q[$];
    int                   n_mismatch = 0;
    int                   num_checks = 0;

    always #50 clk_i = ~clk_i;

    srgc_host_model u_host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

    srgc_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .second_port_select_i(sel),
        .strap_i(strap), .strap_val_o(strap_val), .strap_reload_o(reload),
        .restore_regs_o(restore), .logic_rst_o(lrst), .crc_chk_en_o(crc_en),
        .rem_wr_start_i(rws), .rem_port_i(rport), .rem_other_slave_i(roth),
        .pass_all_i(pall), .rem_resp_i(rresp), .rem_nack_i(rnack), .local_ack_o(lack),
        .local_nack_o(lnack), .alias_match_i(amatch), .alias_port_i(aport),
        .fwd_remote_o(fwd), .sync_i(sync_i), .sync_o(sync_o));

    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task take(input logic [15:0] seen);
        // No result carries the tag ff, so an unexpected one always counts.
        if (exp_q.size() == 0)
            check(seen, 16'hffff);
        else
            check(seen, exp_q.pop_front());
    endtask : take

    task rd_chk(input logic [7:0] ad, input logic [7:0] e);
        u_host.rd(ad);
        exp_q.push_back({8'h01, e});
    endtask : rd_chk

    function logic [7:0] cfg_exp(input logic ps);
        return {crc, 1'b1, aack[ps], filt, pass[ps], 3'b010};
    endfunction : cfg_exp

    task print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // Every read, acknowledge, forward and logic reset result takes the oldest expectation.
    always @(posedge clk_i)
    begin
        rd_d      <= rd;
        sync_seen <= sync_seen | sync_o;
        if (rd_d)
            take({8'h01, rdata});
        if (lack | lnack)
            take({14'h0080, lnack, lack});
        if (fwd)
            take(16'h0301);
        if (lrst)
            take({13'h0080, reload, restore, lrst});
    end

    initial
    begin
        #500_000;
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(32'h35ed));
        strap <= 8'($urandom);
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        crc = 1'b1;
        filt = 1'b1;
        aack = '{1'b0, 1'b0};
        pass = '{1'b0, 1'b0};
        repeat (8) @(posedge clk_i);
        check({8'h00, strap_val}, {8'h00, strap});
        check({15'h0, crc_en}, 16'h0001);
        rd_chk(8'h03, 8'hd2);
        rd_chk(8'h7f, 8'h00);
        rd_chk(8'h01, 8'h00);
        $display("test defaults done");
        repeat (6)
        begin
            d = 8'($urandom);
            p = 1'($urandom);
            sel <= p;
            u_host.wr(8'h03, d);
            crc = d[7];
            aack[p] = d[5];
            filt = d[4];
            pass[p] = d[3];
            rd_chk(8'h03, cfg_exp(p));
            sel <= ~p;
            rd_chk(8'h03, cfg_exp(~p));
            check({15'h0, crc_en}, {15'h0, crc});
        end
        $display("test config done");
        sel <= 1'b0;
        u_host.wr(8'h03, 8'ha8);
        sel <= 1'b1;
        u_host.wr(8'h03, 8'h90);
        crc = 1'b1;
        filt = 1'b1;
        aack = '{1'b1, 1'b0};
        pass = '{1'b1, 1'b0};
        repeat (10)
        begin
            p = 1'($urandom);
            o = 1'($urandom);
            a = 1'($urandom);
            n = 1'($urandom);
            auto = aack[p] && (!o || a);
            if (auto)
                exp_q.push_back(16'h0201);
            @(posedge clk_i);
            rws <= 1'b1;
            rport <= p;
            roth <= o;
            pall <= a;
            @(posedge clk_i);
            rws <= 1'b0;
            rport <= ~p;
            repeat (3) @(posedge clk_i);
            if (!auto)
                exp_q.push_back({14'h0080, n, !n});
            rresp <= 1'b1;
            rnack <= n;
            @(posedge clk_i);
            rresp <= 1'b0;
            rnack <= ~n;
            repeat (3) @(posedge clk_i);
        end
        $display("test acknowledge done");
        for (int i = 0; i < 4; i++)
        begin
            if (pass[i[0]])
                exp_q.push_back(16'h0301);
            amatch <= 1'b1;
            aport <= i[0];
            @(posedge clk_i);
            amatch <= 1'b0;
            aport <= ~i[0];
            repeat (3) @(posedge clk_i);
        end
        $display("test forward done");
        exp_q.push_back(16'h0407);
        u_host.wr(8'h01, 8'h01);
        rd_chk(8'h01, 8'h00);
        sel <= 1'b0;
        rd_chk(8'h03, cfg_exp(1'b0));
        check({8'h00, strap_val}, {8'h00, strap});
        // Clear the CRC enable first so that the full reset has something to restore.
        u_host.wr(8'h03, 8'h00);
        exp_q.push_back(16'h0401);
        u_host.wr(8'h01, 8'h02);
        // The configuration returns to its default two edges after the write.
        @(posedge clk_i);
        rd_chk(8'h03, 8'hd2);
        repeat (2) @(posedge clk_i);
        check({15'h0, crc_en}, 16'h0001);
        $display("test resets done");
        sync_i <= 3'h7;
        @(posedge clk_i);
        sync_i <= 3'h0;
        repeat (8) @(posedge clk_i);
        check({13'h0, sync_seen}, 16'h0000);
        sync_i <= 3'h7;
        repeat (3) @(posedge clk_i);
        sync_i <= 3'h0;
        repeat (8) @(posedge clk_i);
        check({13'h0, sync_seen}, 16'h0007);
        // With the filter off a single-cycle pulse must pass.
        u_host.wr(8'h03, 8'h80);
        sync_i <= 3'h7;
        @(posedge clk_i);
        sync_i <= 3'h0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check({13'h0, sync_o}, 16'h0007);
        $display("test filter done");
        check(16'(exp_q.size()), 16'h0000);
        print_verdict();
    end
endmodule : tb_serializer_reset_and_general_config
